// ==== bench/cppc_board_model.sv ====
// Board model that drives the sleep request pins and programming events
`timescale 1ns/10ps
module cppc_board_model
(
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Commands from the bench
   input  wire logic [1:0] sleep_cmd_i,
   input  wire logic [3:0] prog_cmd_i,
   // Board outputs
   output logic            sleep_a_o,
   output logic            sleep_b_o,
   output logic            start_o,
   output logic            done_o,
   output logic            abort_o,
   output logic            erase_o
);
   logic [4:0] quiet_r;

   // ****************************************************************
   // Board lines stay quiet until the reset delay has run out
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         quiet_r <= 5'h0B;
      else if (quiet_r != 5'h00)
         quiet_r <= quiet_r - 5'h01;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || quiet_r != 5'h00)
      begin
         {sleep_b_o, sleep_a_o}                 <= 2'h0;
         {erase_o, abort_o, done_o, start_o}    <= 4'h0;
      end
      else
      begin
         {sleep_b_o, sleep_a_o}                 <= sleep_cmd_i;
         {erase_o, abort_o, done_o, start_o}    <= prog_cmd_i;
      end
   end
endmodule : cppc_board_model

// ==== bench/cppc_power_ctrl_test.sv ====
// Self-checking bench for the power and protection control block
`timescale 1ns/10ps
module cppc_power_ctrl_test;
   logic        core_clk_i, rst_i = 1'b1, pd_enable_i = 1'b1;
   logic        keeper_en_i = 1'b0, auto_standby_en_i = 1'b0;
   logic        isp_disable_i = 1'b0, security_fuse_i = 1'b0;
   logic [15:0] fast_slew_i = 16'h0000, mc_reduced_pwr_i = 16'h0000;
   logic [15:0] user_sig_i = 16'h5A17, pattern_i = 16'hC3A5;
   logic [15:0] core_next_i = 16'h0000, core_oe_i = 16'h0000;
   logic [15:0] pad_in_i = 16'h0000, pad_driven_i = 16'h0000;
   logic [3:0]  isp_pad_in_i = 4'h0, prog_cmd = 4'h0;
   logic [1:0]  sleep_cmd = 2'h0;
   logic        verify_req_i = 1'b0, sig_req_i = 1'b0;
   logic        sleep_request_pin_a, sleep_request_pin_b;
   logic        prog_start_i, prog_done_i, prog_abort_i, erase_i;
   logic [15:0] pad_out_o, pad_oe_n_o, pad_fast_o, pad_level_o;
   logic [15:0] core_state_o, mc_active_o, read_data_o;
   logic [3:0]  isp_gpio_o;
   logic        read_valid_o, read_refused_o, sleeping_o, standby_o;
   logic        locked_o, erased_o;
   int          errors = 0, check_count = 0;

   cppc_power_ctrl dut
   (
      .core_clk_i, .rst_i, .pd_enable_i, .keeper_en_i, .auto_standby_en_i,
      .isp_disable_i, .security_fuse_i, .fast_slew_i, .mc_reduced_pwr_i,
      .user_sig_i, .pattern_i, .sleep_request_pin_a, .sleep_request_pin_b,
      .prog_start_i, .prog_done_i, .prog_abort_i, .erase_i, .verify_req_i,
      .sig_req_i, .core_next_i, .core_oe_i, .pad_in_i, .pad_driven_i,
      .isp_pad_in_i, .pad_out_o, .pad_oe_n_o, .pad_fast_o, .pad_level_o,
      .core_state_o, .mc_active_o, .isp_gpio_o, .read_data_o, .read_valid_o,
      .read_refused_o, .sleeping_o, .standby_o, .locked_o, .erased_o
   );

   cppc_board_model board
   (
      .core_clk_i, .rst_i, .sleep_cmd_i(sleep_cmd), .prog_cmd_i(prog_cmd),
      .sleep_a_o(sleep_request_pin_a), .sleep_b_o(sleep_request_pin_b),
      .start_o(prog_start_i), .done_o(prog_done_i),
      .abort_o(prog_abort_i), .erase_o(erase_i)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   task cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc

   // Waits at falling edges for a status flag, bounded
   task wait_flag(input int sel, input logic want);
      logic got;
      for (int i = 0; i < 40; i++)
      begin
         @(negedge core_clk_i);
         got = (sel == 0) ? sleeping_o : (sel == 1) ? standby_o : locked_o;
         if (got === want)
            break;
      end
      check({15'h0000, got}, {15'h0000, want});
      if (got !== want)
         complete_run();
   endtask : wait_flag

   // One-cycle read request; data compared only when answered
   task rd(input logic ver, input logic [15:0] dat, input logic [1:0] ans);
      cyc(1);
      verify_req_i <= ver;
      sig_req_i    <= ~ver;
      cyc(1);
      verify_req_i <= 1'b0;
      sig_req_i    <= 1'b0;
      @(negedge core_clk_i);
      check({14'h0000, read_refused_o, read_valid_o}, {14'h0000, ans});
      if (ans != 2'h0)
         check(read_data_o, dat);
   endtask : rd

   initial
   begin
      #100000;
      errors++;
      complete_run();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      cyc(3);
      @(negedge core_clk_i);
      check(core_state_o, 16'h0000);
      check(pad_oe_n_o, 16'hFFFF);
      check(pad_fast_o, 16'h0000);
      check({15'h0000, erased_o}, 16'h0001);
      cyc(1);
      rst_i <= 1'b0;
      cyc(12);
      fast_slew_i      <= 16'h00A5;
      mc_reduced_pwr_i <= 16'hF000;
      core_oe_i        <= 16'hFFFF;
      core_next_i      <= 16'h1234;
      isp_disable_i    <= 1'b1;
      isp_pad_in_i     <= 4'hA;
      cyc(4);
      @(negedge core_clk_i);
      check(pad_fast_o, 16'h00A5);
      check(mc_active_o, 16'h0FFF);
      check(pad_oe_n_o, 16'h0003);
      check(core_state_o, 16'h0234);
      check(pad_out_o, 16'h0234);
      check({12'h000, isp_gpio_o}, 16'h000A);
      for (int f = 0; f < 2; f++)
      begin
         cyc(1);
         security_fuse_i <= f[0];
         rd(1'b1, f ? 16'h0000 : 16'hC3A5, f ? 2'h2 : 2'h1);
         rd(1'b0, 16'h5A17, 2'h1);
      end
      cyc(1);
      keeper_en_i  <= 1'b1;
      pad_driven_i <= 16'h0020;
      pad_in_i     <= 16'h0020;
      cyc(2);
      pad_driven_i <= 16'h0000;
      pad_in_i     <= 16'h0000;
      cyc(3);
      @(negedge core_clk_i);
      check(pad_level_o & 16'h0020, 16'h0020);
      cyc(1);
      auto_standby_en_i <= 1'b1;
      wait_flag(1, 1'b1);
      cyc(1);
      pad_in_i <= 16'h0100;
      wait_flag(1, 1'b0);
      cyc(1);
      auto_standby_en_i <= 1'b0;
      // Unused macrocells 12 to 15 keep their core bits low
      for (int p = 0; p < 2; p++)
      begin
         cyc(1);
         sleep_cmd <= p ? 2'h2 : 2'h1;
         wait_flag(0, 1'b1);
         cyc(1);
         core_next_i <= p ? 16'h1234 : 16'hBEEF;
         rd(1'b1, 16'h0000, 2'h0);
         cyc(3);
         @(negedge core_clk_i);
         check(core_state_o, p ? 16'h0EEF : 16'h0234);
         check(pad_out_o, p ? 16'h0EEF : 16'h0234);
         check(pad_oe_n_o, 16'h0003);
         cyc(1);
         sleep_cmd <= 2'h0;
         wait_flag(0, 1'b0);
         cyc(3);
         @(negedge core_clk_i);
         check(core_state_o, p ? 16'h0234 : 16'h0EEF);
      end
      // Power-down option off: request pins ignored, pins 0 and 1 usable
      cyc(1);
      pd_enable_i <= 1'b0;
      sleep_cmd   <= 2'h1;
      cyc(4);
      @(negedge core_clk_i);
      check({15'h0000, sleeping_o}, 16'h0000);
      check(pad_oe_n_o, 16'h0000);
      cyc(1);
      sleep_cmd <= 2'h0;
      cyc(3);
      pd_enable_i <= 1'b1;
      cyc(1);
      prog_cmd <= 4'h1;
      cyc(1);
      prog_cmd <= 4'h0;
      cyc(3);
      @(negedge core_clk_i);
      check(pad_level_o & 16'h0020, 16'h0020);
      cyc(1);
      prog_cmd <= 4'h4;
      cyc(1);
      prog_cmd <= 4'h0;
      wait_flag(2, 1'b1);
      cyc(2);
      @(negedge core_clk_i);
      check(pad_oe_n_o, 16'hFFFF);
      cyc(1);
      keeper_en_i <= 1'b0;
      cyc(2);
      @(negedge core_clk_i);
      check(pad_level_o & 16'h0020, 16'h0000);
      // Restart programming from lock, finish it, then erase again
      cyc(1);
      prog_cmd <= 4'h1;
      cyc(1);
      prog_cmd <= 4'h2;
      cyc(1);
      prog_cmd <= 4'h0;
      cyc(3);
      @(negedge core_clk_i);
      check({14'h0000, locked_o, erased_o}, 16'h0000);
      check(core_state_o, 16'h0000);
      cyc(11);
      prog_cmd <= 4'h1;
      cyc(1);
      prog_cmd <= 4'h8;
      cyc(1);
      prog_cmd <= 4'h0;
      cyc(2);
      @(negedge core_clk_i);
      check({15'h0000, erased_o}, 16'h0001);
      complete_run();
   end
endmodule : cppc_power_ctrl_test

// ==== common/cppc_pkg.sv ====
// Constants and types shared by the power and protection control block
package cppc_pkg;

   // ****************************************************************
   // Sizes and counts
   // ****************************************************************
   localparam int unsigned PIN_COUNT     = 16;
   localparam int unsigned ISP_PIN_COUNT = 4;
   localparam int unsigned SIG_WIDTH     = 16;
   localparam int unsigned CLK_PERIOD_NS = 4;
   // Idle time before automatic standby, in ns, and derived cycles
   localparam int unsigned IDLE_TIME_NS  = 64;
   localparam int unsigned IDLE_CYCLES   =
      (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Power-up reset delay before registers release
   localparam int unsigned RST_DELAY_NS  = 40;
   localparam int unsigned RST_CYCLES    =
      (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  CNT_ZERO      = 8'h00;
   localparam logic        REG_RESET_VAL = 1'b0;
   localparam logic        SLEW_SLOW     = 1'b0;

   // ****************************************************************
   // Operating states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_INIT,
      ST_RUN,
      ST_STANDBY,
      ST_SLEEP,
      ST_PROG,
      ST_LOCKED
   } cppc_state_e;

endpackage : cppc_pkg

// ==== verilog/cppc_pin_cell.sv ====
// One pin cell: keeper, high-Z lock, slew select and frozen output
`timescale 1ns/10ps
module cppc_pin_cell
(
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic freeze_i,
   input  wire logic lock_i,
   input  wire logic keeper_en_i,
   input  wire logic fast_slew_i,
   input  wire logic pin_usable_i,
   // Core side
   input  wire logic core_out_i,
   input  wire logic core_oe_i,
   // Pad side
   input  wire logic pad_in_i,
   input  wire logic pad_driven_i,
   output logic      pad_out_o,
   output logic      pad_oe_n_o,
   output logic      pad_fast_o,
   output logic      pad_level_o
);
   logic out_r,  out_nxt;
   logic oe_n_r, oe_n_nxt;
   logic keep_r, keep_nxt;
   logic fast_r, fast_nxt;
   logic level_r, level_nxt;

   always_comb
   begin
      out_nxt  = out_r;
      oe_n_nxt = oe_n_r;
      keep_nxt = keep_r;
      fast_nxt = fast_r;
      if (lock_i)
      begin
         oe_n_nxt = 1'b1;
      end
      else if (!freeze_i)
      begin
         out_nxt  = core_out_i;
         oe_n_nxt = !(core_oe_i && pin_usable_i);
         fast_nxt = fast_slew_i;
      end
      // Keeper tracks only while the pad is actually driven
      if (pad_driven_i)
      begin
         keep_nxt = pad_in_i;
      end
      // Level seen at the pad: driven, kept, or low when keeper off
      level_nxt = pad_driven_i ? pad_in_i
                : (keeper_en_i ? keep_r : 1'b0);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         out_r  <= cppc_pkg::REG_RESET_VAL;
         oe_n_r <= 1'b1;
         keep_r <= cppc_pkg::REG_RESET_VAL;
         fast_r <= cppc_pkg::SLEW_SLOW;
         level_r <= cppc_pkg::REG_RESET_VAL;
      end
      else
      begin
         out_r  <= out_nxt;
         oe_n_r <= oe_n_nxt;
         keep_r <= keep_nxt;
         fast_r <= fast_nxt;
         level_r <= level_nxt;
      end
   end

   // Outputs straight from flip-flops
   always_comb
   begin
      pad_out_o   = out_r;
      pad_oe_n_o  = oe_n_r;
      pad_fast_o  = fast_r;
      pad_level_o = level_r;
   end

endmodule : cppc_pin_cell

// ==== verilog/cppc_power_ctrl.sv ====
// Power-down, standby, reset and programming protection control
`timescale 1ns/10ps
module cppc_power_ctrl
#(
   parameter int unsigned PINS = cppc_pkg::PIN_COUNT,
   parameter int unsigned ISPN = cppc_pkg::ISP_PIN_COUNT,
   parameter int unsigned SIGW = cppc_pkg::SIG_WIDTH
)
(
   // Clock and reset
   input  wire logic            core_clk_i,
   input  wire logic            rst_i,
   // Configuration options
   input  wire logic            pd_enable_i,
   input  wire logic            keeper_en_i,
   input  wire logic            auto_standby_en_i,
   input  wire logic            isp_disable_i,
   input  wire logic            security_fuse_i,
   input  wire logic [PINS-1:0] fast_slew_i,
   input  wire logic [PINS-1:0] mc_reduced_pwr_i,
   input  wire logic [SIGW-1:0] user_sig_i,
   input  wire logic [PINS-1:0] pattern_i,
   // Sleep request pins
   input  wire logic            sleep_request_pin_a,
   input  wire logic            sleep_request_pin_b,
   // Programming control
   input  wire logic            prog_start_i,
   input  wire logic            prog_done_i,
   input  wire logic            prog_abort_i,
   input  wire logic            erase_i,
   input  wire logic            verify_req_i,
   input  wire logic            sig_req_i,
   // Core logic
   input  wire logic [PINS-1:0] core_next_i,
   input  wire logic [PINS-1:0] core_oe_i,
   // Pads
   input  wire logic [PINS-1:0] pad_in_i,
   input  wire logic [PINS-1:0] pad_driven_i,
   input  wire logic [ISPN-1:0] isp_pad_in_i,
   // Outputs
   output logic [PINS-1:0]      pad_out_o,
   output logic [PINS-1:0]      pad_oe_n_o,
   output logic [PINS-1:0]      pad_fast_o,
   output logic [PINS-1:0]      pad_level_o,
   output logic [PINS-1:0]      core_state_o,
   output logic [PINS-1:0]      mc_active_o,
   output logic [ISPN-1:0]      isp_gpio_o,
   output logic [SIGW-1:0]      read_data_o,
   output logic                 read_valid_o,
   output logic                 read_refused_o,
   output logic                 sleeping_o,
   output logic                 standby_o,
   output logic                 locked_o,
   output logic                 erased_o
);
   default clocking chk_cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // ****************************************************************
   // State
   // ****************************************************************
   cppc_pkg::cppc_state_e state_r, state_nxt;
   logic [7:0]      cnt_r,    cnt_nxt;
   logic [PINS-1:0] core_r,   core_nxt;
   logic [PINS-1:0] mc_r,     mc_nxt;
   logic [PINS-1:0] pin_q_r,  pin_q_nxt;
   logic [ISPN-1:0] isp_r,    isp_nxt;
   logic [SIGW-1:0] rd_r,     rd_nxt;
   logic            rdv_r,    rdv_nxt;
   logic            rdx_r,    rdx_nxt;
   logic            erased_r, erased_nxt;
   logic            sleep_r,  sleep_nxt;
   logic            stby_r,   stby_nxt;
   logic            lock_r,   lock_nxt;
   logic            sleep_req;
   logic            activity;
   logic            freeze;
   logic            lock;

   // Pads stay frozen in init and sleep; lock releases on reset or on prog_start_i
   assign sleep_req = pd_enable_i
                    && (sleep_request_pin_a || sleep_request_pin_b);
   assign activity  = (pad_in_i != pin_q_r);
   assign freeze    = (state_r == cppc_pkg::ST_SLEEP)
                   || (state_r == cppc_pkg::ST_INIT);
   assign lock      = (state_r == cppc_pkg::ST_LOCKED);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb
   begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      core_nxt   = core_r;
      mc_nxt     = mc_r;
      pin_q_nxt  = pin_q_r;
      isp_nxt    = isp_r;
      rd_nxt     = rd_r;
      rdv_nxt    = 1'b0;
      rdx_nxt    = 1'b0;
      erased_nxt = erased_r;
      case (state_r)
         cppc_pkg::ST_INIT:
         begin
            // Core state held low for the reset delay
            if (cnt_r == 8'(cppc_pkg::RST_CYCLES - 1))
            begin
               state_nxt = cppc_pkg::ST_RUN;
               cnt_nxt   = cppc_pkg::CNT_ZERO;
            end
            else
            begin
               cnt_nxt = cnt_r + 8'h01;
            end
         end
         cppc_pkg::ST_RUN, cppc_pkg::ST_STANDBY:
         begin
            pin_q_nxt = pad_in_i;
            mc_nxt    = ~mc_reduced_pwr_i;
            core_nxt  = core_next_i & ~mc_reduced_pwr_i;
            if (!isp_disable_i)
            begin
               isp_nxt = '0;
            end
            else
            begin
               isp_nxt = isp_pad_in_i;
            end
            if (sleep_req)
            begin
               state_nxt = cppc_pkg::ST_SLEEP;
               core_nxt  = core_r;
            end
            else if (prog_start_i)
            begin
               state_nxt = cppc_pkg::ST_PROG;
            end
            else if (activity || !auto_standby_en_i)
            begin
               state_nxt = cppc_pkg::ST_RUN;
               cnt_nxt   = cppc_pkg::CNT_ZERO;
            end
            else if (cnt_r == 8'(cppc_pkg::IDLE_CYCLES - 1))
            begin
               state_nxt = cppc_pkg::ST_STANDBY;
            end
            else
            begin
               cnt_nxt = cnt_r + 8'h01;
            end
            if (verify_req_i)
            begin
               rdv_nxt = !security_fuse_i;
               rdx_nxt = security_fuse_i;
               rd_nxt  = security_fuse_i ? '0 : SIGW'(pattern_i);
            end
            else if (sig_req_i)
            begin
               rdv_nxt = 1'b1;
               rd_nxt  = user_sig_i;
            end
         end
         cppc_pkg::ST_SLEEP:
         begin
            // Pin changes ignored; resume from latched core state
            if (!sleep_req)
            begin
               state_nxt = cppc_pkg::ST_RUN;
               cnt_nxt   = cppc_pkg::CNT_ZERO;
               pin_q_nxt = pad_in_i;
            end
         end
         cppc_pkg::ST_PROG:
         begin
            if (erase_i)
            begin
               erased_nxt = 1'b1;
            end
            if (prog_abort_i)
            begin
               state_nxt = cppc_pkg::ST_LOCKED;
            end
            else if (prog_done_i)
            begin
               state_nxt  = cppc_pkg::ST_INIT;
               erased_nxt = 1'b0;
               cnt_nxt    = cppc_pkg::CNT_ZERO;
               core_nxt   = '0;
            end
         end
         cppc_pkg::ST_LOCKED:
         begin
            if (prog_start_i)
            begin
               state_nxt = cppc_pkg::ST_PROG;
            end
         end
         default:
         begin
            state_nxt = cppc_pkg::ST_INIT;
         end
      endcase
      sleep_nxt = (state_nxt == cppc_pkg::ST_SLEEP);
      stby_nxt  = (state_nxt == cppc_pkg::ST_STANDBY);
      lock_nxt  = (state_nxt == cppc_pkg::ST_LOCKED);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_r  <= cppc_pkg::ST_INIT;
         cnt_r    <= cppc_pkg::CNT_ZERO;
         core_r   <= '0;
         mc_r     <= '0;
         pin_q_r  <= '0;
         isp_r    <= '0;
         rd_r     <= '0;
         rdv_r    <= 1'b0;
         rdx_r    <= 1'b0;
         erased_r <= 1'b1;
         sleep_r  <= 1'b0;
         stby_r   <= 1'b0;
         lock_r   <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         core_r   <= core_nxt;
         mc_r     <= mc_nxt;
         pin_q_r  <= pin_q_nxt;
         isp_r    <= isp_nxt;
         rd_r     <= rd_nxt;
         rdv_r    <= rdv_nxt;
         rdx_r    <= rdx_nxt;
         erased_r <= erased_nxt;
         sleep_r  <= sleep_nxt;
         stby_r   <= stby_nxt;
         lock_r   <= lock_nxt;
      end
   end

   // ****************************************************************
   // Pin cells
   // ****************************************************************
   for (genvar g = 0; g < PINS; g++)
   begin : g_pin
      cppc_pin_cell u_cell
      (
         .core_clk_i   (core_clk_i),
         .rst_i        (rst_i),
         .freeze_i     (freeze || state_r == cppc_pkg::ST_PROG),
         .lock_i       (lock),
         .keeper_en_i  (keeper_en_i),
         .fast_slew_i  (fast_slew_i[g]),
         // Pins 0 and 1 serve as sleep requests when enabled
         .pin_usable_i (!(pd_enable_i && g < 2)),
         .core_out_i   (core_r[g]),
         .core_oe_i    (core_oe_i[g]),
         .pad_in_i     (pad_in_i[g]),
         .pad_driven_i (pad_driven_i[g]),
         .pad_out_o    (pad_out_o[g]),
         .pad_oe_n_o   (pad_oe_n_o[g]),
         .pad_fast_o   (pad_fast_o[g]),
         .pad_level_o  (pad_level_o[g])
      );
   end

   always_comb
   begin
      core_state_o   = core_r;
      mc_active_o    = mc_r;
      isp_gpio_o     = isp_r;
      read_data_o    = rd_r;
      read_valid_o   = rdv_r;
      read_refused_o = rdx_r;
      sleeping_o     = sleep_r;
      standby_o      = stby_r;
      locked_o       = lock_r;
      erased_o       = erased_r;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sleep_entry_a: assert property
      ((state_r == cppc_pkg::ST_RUN && sleep_req) |=> sleeping_o)
      else $error("sleep not entered on request");
   sleep_hold_a: assert property
      ((sleeping_o && sleep_req) |=> $stable(core_r))
      else $error("core state changed while asleep");
   sleep_exit_a: assert property
      ((sleeping_o && !sleep_req) |=> !sleeping_o)
      else $error("sleep not left after request drop");
   fuse_block_a: assert property
      ((state_r == cppc_pkg::ST_RUN && verify_req_i && security_fuse_i)
      |=> (read_refused_o && !read_valid_o))
      else $error("verify allowed with fuse set");
   abort_lock_a: assert property
      ((state_r == cppc_pkg::ST_PROG && prog_abort_i) |=> ##1 (&pad_oe_n_o))
      else $error("pins driven after aborted programming");
   init_clear_a: assert property
      ($fell(rst_i) |-> (core_r == '0 && state_r == cppc_pkg::ST_INIT))
      else $error("registers not cleared after reset");
   mc_power_a: assert property
      ((state_r == cppc_pkg::ST_RUN && !sleep_req && !prog_start_i)
      |=> ((core_r & $past(mc_reduced_pwr_i)) == '0))
      else $error("reduced power macrocell active");
   standby_idle_a: assert property
      ((standby_o && activity && !sleep_req && !prog_start_i) |=> !standby_o)
      else $error("standby not left on activity");
   isp_port_a: assert property
      ((state_r == cppc_pkg::ST_RUN && !isp_disable_i)
      |=> (isp_gpio_o == '0))
      else $error("programming pins freed while port enabled");
   lock_hold_a: assert property
      ((locked_o && !prog_start_i) |=> locked_o)
      else $error("lock released without new programming");

endmodule : cppc_power_ctrl
